/* File: cab_pkg.sv */
/*
  cab_pkg: constants and types shared by the alu/branch execute block.
  assumes: the fetch stage delivers instructions already split into
  the fields of cab_instr_t; opcode bit patterns live there, not here.
*/
package cab_pkg;
  // ----------------------------------------
  // sizes and bit positions
  // ----------------------------------------
  localparam int unsigned RN = 32;
  localparam int unsigned MSB = 7;
  localparam int unsigned HALF_B = 3;
  localparam int unsigned W_MSB = 15;
  localparam int unsigned K_MSB = 6;
  localparam int unsigned K_W = 7;

  // status flag positions
  localparam int unsigned FL_C = 0;
  localparam int unsigned FL_Z = 1;
  localparam int unsigned FL_N = 2;
  localparam int unsigned FL_V = 3;
  localparam int unsigned FL_S = 4;
  localparam int unsigned FL_H = 5;

  // ----------------------------------------
  // fixed registers and reset values
  // ----------------------------------------
  localparam logic [4:0] REG_PROD_LO = 5'h00;
  localparam logic [4:0] REG_PROD_HI = 5'h01;
  localparam logic [4:0] REG_ZPTR_LO = 5'h1e;
  localparam logic [4:0] REG_ZPTR_HI = 5'h1f;
  localparam logic [4:0] REG_STEP = 5'h01;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] STATUS_FLAGS_REG_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] IMM_PAIR_MASK = 8'h3f;

  // ----------------------------------------
  // cycle counts and program counter steps
  // ----------------------------------------
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;
  localparam logic [1:0] CYC_3 = 2'h3;
  localparam int unsigned PC_NEXT = 1;
  localparam int unsigned PC_SKIP_ONE = 2;
  localparam int unsigned PC_SKIP_TWO = 3;

  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [5:0] {
    nop_op = 6'h00, add_regs_op = 6'h01, add_carry_op = 6'h02,
    sub_regs_op = 6'h03, sub_const_op = 6'h04, sub_carry_op = 6'h05,
    sub_const_carry_op = 6'h06, and_regs_op = 6'h07, and_const_op = 6'h08,
    or_regs_op = 6'h09, or_const_op = 6'h0a, xor_regs_op = 6'h0b,
    clear_mask_op = 6'h0c, zero_minus_test_op = 6'h0d, cmp_regs_op = 6'h0e,
    cmp_carry_op = 6'h0f, cmp_imm_op = 6'h10, add_imm_pair_op = 6'h11,
    sub_imm_pair_op = 6'h12, mult_unsigned_op = 6'h13, mult_signed_op = 6'h14,
    mult_signed_unsigned_op = 6'h15, frac_mult_unsigned_op = 6'h16,
    frac_mult_signed_op = 6'h17, frac_mult_mixed_op = 6'h18,
    pointer_jump_op = 6'h19, pointer_call_op = 6'h1a, cmp_skip_equal_op = 6'h1b,
    skip_reg_bit_clear_op = 6'h1c, skip_io_bit_set_op = 6'h1d,
    branch_status_set_op = 6'h1e, branch_same_higher_op = 6'h1f,
    branch_signed_ge_op = 6'h20, branch_carry_clear_op = 6'h21
  } cab_op_t;

  // imm carries constant k, pair constant (low six bits) or branch offset (low seven bits)
  typedef struct packed {
    cab_op_t op;
    logic [4:0] rd;
    logic [4:0] src_reg;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic next_two_word;
  } cab_instr_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] status_flags_reg;
  } cab_alu_res_t;
endpackage

/* File: cab_alu.sv */
/*
  cab_alu: combinational result and status flag logic.
  assumes: operands come straight from the register file of cab_core;
  the caller decides which registers get written.
*/
`timescale 1ns/1ps
module cab_alu (
  // operation and operands
  input wire cab_pkg::cab_op_t op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] a_hi_i,
  input wire logic [7:0] r_i,
  input wire logic [7:0] imm_i,
  input wire logic [7:0] status_flags_reg_i,
  // results and next status flags
  output cab_pkg::cab_alu_res_t res_o
);
  import cab_pkg::*;

  logic [7:0] b;
  logic cin;
  logic is_sub;
  logic z_chain;
  logic [7:0] s;
  logic h_add, h_sub, c_add, c_sub, v_add, v_sub;
  logic [15:0] w_in;
  logic [15:0] w;
  logic signed [8:0] ma;
  logic signed [8:0] mb;
  logic signed [17:0] p;
  logic [15:0] m;

  // ----------------------------------------
  // operand selection
  // ----------------------------------------
  always_comb begin
    case (op_i)
      sub_const_op, sub_const_carry_op, and_const_op, or_const_op, cmp_imm_op: b = imm_i;
      clear_mask_op: b = ALL_ONES - imm_i;
      zero_minus_test_op: b = a_i;
      default: b = r_i;
    endcase
  end

  always_comb begin
    case (op_i)
      add_carry_op, sub_carry_op, sub_const_carry_op, cmp_carry_op: cin = status_flags_reg_i[FL_C];
      default: cin = 1'b0;
    endcase
  end

  assign is_sub = op_i inside {sub_regs_op, sub_const_op, sub_carry_op, sub_const_carry_op,
                               cmp_regs_op, cmp_carry_op, cmp_imm_op};
  // subtract and compare carry-in forms keep zero only if the previous byte was zero too, so chains work
  assign z_chain = op_i inside {sub_carry_op, sub_const_carry_op, cmp_carry_op};
  assign s = is_sub ? a_i - b - {7'h00, cin} : a_i + b + {7'h00, cin};

  assign h_add = (a_i[HALF_B] & b[HALF_B]) | (b[HALF_B] & ~s[HALF_B]) | (~s[HALF_B] & a_i[HALF_B]);
  assign h_sub = (~a_i[HALF_B] & b[HALF_B]) | (b[HALF_B] & s[HALF_B]) | (s[HALF_B] & ~a_i[HALF_B]);
  assign c_add = (a_i[MSB] & b[MSB]) | (b[MSB] & ~s[MSB]) | (~s[MSB] & a_i[MSB]);
  assign c_sub = (~a_i[MSB] & b[MSB]) | (b[MSB] & s[MSB]) | (s[MSB] & ~a_i[MSB]);
  assign v_add = (a_i[MSB] & b[MSB] & ~s[MSB]) | (~a_i[MSB] & ~b[MSB] & s[MSB]);
  assign v_sub = (a_i[MSB] & ~b[MSB] & ~s[MSB]) | (~a_i[MSB] & b[MSB] & s[MSB]);

  // ----------------------------------------
  // word and multiply datapaths
  // ----------------------------------------
  assign w_in = {a_hi_i, a_i};
  assign w = (op_i == sub_imm_pair_op) ? w_in - {8'h00, imm_i & IMM_PAIR_MASK}
                                       : w_in + {8'h00, imm_i & IMM_PAIR_MASK};

  assign ma = (op_i inside {mult_signed_op, mult_signed_unsigned_op, frac_mult_signed_op,
               frac_mult_mixed_op}) ? signed'({a_i[MSB], a_i}) : signed'({1'b0, a_i});
  assign mb = (op_i inside {mult_signed_op, frac_mult_signed_op}) ? signed'({r_i[MSB], r_i})
                                                                 : signed'({1'b0, r_i});
  assign p = ma * mb;
  assign m = (op_i inside {frac_mult_unsigned_op, frac_mult_signed_op, frac_mult_mixed_op})
             ? {p[W_MSB-1:0], 1'b0} : p[W_MSB:0];

  // ----------------------------------------
  // results and flags
  // ----------------------------------------
  always_comb begin
    res_o.lo = s;
    res_o.hi = a_hi_i;
    res_o.status_flags_reg = status_flags_reg_i;
    case (op_i)
      add_regs_op, add_carry_op, sub_regs_op, sub_const_op, sub_carry_op, sub_const_carry_op,
      cmp_regs_op, cmp_carry_op, cmp_imm_op: begin
        res_o.status_flags_reg[FL_H] = is_sub ? h_sub : h_add;
        res_o.status_flags_reg[FL_C] = is_sub ? c_sub : c_add;
        res_o.status_flags_reg[FL_V] = is_sub ? v_sub : v_add;
        res_o.status_flags_reg[FL_N] = s[MSB];
        res_o.status_flags_reg[FL_S] = s[MSB] ^ res_o.status_flags_reg[FL_V];
        res_o.status_flags_reg[FL_Z] = (s == '0) & (z_chain ? status_flags_reg_i[FL_Z] : 1'b1);
      end
      and_regs_op, and_const_op, clear_mask_op, zero_minus_test_op: begin
        res_o.lo = a_i & b;
        res_o.status_flags_reg[FL_V] = 1'b0;
        res_o.status_flags_reg[FL_N] = res_o.lo[MSB];
        res_o.status_flags_reg[FL_S] = res_o.lo[MSB];
        res_o.status_flags_reg[FL_Z] = (res_o.lo == '0);
      end
      or_regs_op, or_const_op, xor_regs_op: begin
        res_o.lo = (op_i == xor_regs_op) ? a_i ^ b : a_i | b;
        res_o.status_flags_reg[FL_V] = 1'b0;
        res_o.status_flags_reg[FL_N] = res_o.lo[MSB];
        res_o.status_flags_reg[FL_S] = res_o.lo[MSB];
        res_o.status_flags_reg[FL_Z] = (res_o.lo == '0);
      end
      add_imm_pair_op, sub_imm_pair_op: begin
        {res_o.hi, res_o.lo} = w;
        res_o.status_flags_reg[FL_V] = (op_i == add_imm_pair_op) ? ~w_in[W_MSB] & w[W_MSB] : w_in[W_MSB] & ~w[W_MSB];
        res_o.status_flags_reg[FL_C] = (op_i == add_imm_pair_op) ? ~w[W_MSB] & w_in[W_MSB] : w[W_MSB] & ~w_in[W_MSB];
        res_o.status_flags_reg[FL_N] = w[W_MSB];
        res_o.status_flags_reg[FL_S] = w[W_MSB] ^ res_o.status_flags_reg[FL_V];
        res_o.status_flags_reg[FL_Z] = (w == '0);
      end
      mult_unsigned_op, mult_signed_op, mult_signed_unsigned_op, frac_mult_unsigned_op,
      frac_mult_signed_op, frac_mult_mixed_op: begin
        {res_o.hi, res_o.lo} = m;
        res_o.status_flags_reg[FL_C] = p[W_MSB];
        res_o.status_flags_reg[FL_Z] = (m == '0);
      end
      default: ;
    endcase
  end
endmodule

/* File: cab_core.sv */
/*
  cab_core: alu, multiply, jump, call, compare, skip and branch execution
  with register file, status flags and program counter.
  assumes: fetch presents one decoded instruction with instr_valid_i and
  holds it until issue_ready_o takes it; io_rdata_i is the addressed i/o
  register, produced on mclk_i by same-clock logic.
*/
`timescale 1ns/1ps
module cab_core #(
  parameter int unsigned PC_W = 16
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // instruction issue
  input wire logic instr_valid_i,
  input wire cab_pkg::cab_instr_t instr_i,
  output logic issue_ready_o,
  // i/o space bit source
  input wire logic [7:0] io_rdata_i,
  // program flow
  output logic [PC_W-1:0] pc_o,
  output logic ret_push_o,
  output logic [PC_W-1:0] ret_addr_o,
  // state observation
  output logic [7:0] status_flags_reg_o,
  input wire logic [4:0] dbg_sel_i,
  output logic [7:0] dbg_data_o
);
  import cab_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // z is sixteen bits wide, so a wider pc could not be loaded from it
  if (PC_W < K_W || PC_W > W_MSB + 1) begin : g_bad_pc_w
    $error("cab_core: PC_W out of range");
  end

  // ----------------------------------------
  // state and nets
  // ----------------------------------------
  logic [7:0] regs_r [RN];
  logic [7:0] status_flags_reg_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [1:0] busy_r;
  logic [1:0] busy_nxt;
  logic ready_r;
  logic ret_push_r;
  logic [PC_W-1:0] ret_addr_r;
  logic [7:0] dbg_r;
  logic take;
  logic [7:0] rd_val;
  logic [7:0] rd_hi_val;
  logic [7:0] rr_val;
  logic [15:0] z_val;
  logic [PC_W-1:0] koff;
  cab_alu_res_t alu_res;
  logic wr_lo;
  logic wr_hi;
  logic [4:0] wr_lo_addr;
  logic [4:0] wr_hi_addr;
  logic [1:0] cyc;
  logic cond;
  logic is_skip;
  logic is_branch;

  assign take = ce_i & instr_valid_i & ready_r;
  assign rd_val = regs_r[instr_i.rd];
  assign rd_hi_val = regs_r[5'(instr_i.rd + REG_STEP)];
  assign rr_val = regs_r[instr_i.src_reg];
  assign z_val = {regs_r[REG_ZPTR_HI], regs_r[REG_ZPTR_LO]};
  // offset is a signed word count relative to the following instruction
  assign koff = {{(PC_W-K_W){instr_i.imm[K_MSB]}}, instr_i.imm[K_MSB:0]};

  cab_alu u_alu (
    .op_i(instr_i.op),
    .a_i(rd_val),
    .a_hi_i(rd_hi_val),
    .r_i(rr_val),
    .imm_i(instr_i.imm),
    .status_flags_reg_i(status_flags_reg_r),
    .res_o(alu_res)
  );

  // ----------------------------------------
  // write-back selection
  // ----------------------------------------
  always_comb begin
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_lo_addr = instr_i.rd;
    wr_hi_addr = 5'(instr_i.rd + REG_STEP);
    case (instr_i.op)
      add_regs_op, add_carry_op, sub_regs_op, sub_const_op, sub_carry_op, sub_const_carry_op,
      and_regs_op, and_const_op, or_regs_op, or_const_op, xor_regs_op, clear_mask_op: begin
        wr_lo = 1'b1;
      end
      add_imm_pair_op, sub_imm_pair_op: begin
        wr_lo = 1'b1;
        wr_hi = 1'b1;
      end
      mult_unsigned_op, mult_signed_op, mult_signed_unsigned_op, frac_mult_unsigned_op,
      frac_mult_signed_op, frac_mult_mixed_op: begin
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        wr_lo_addr = REG_PROD_LO;
        wr_hi_addr = REG_PROD_HI;
      end
      // test and compares are flag-only
      default: ;
    endcase
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  for (genvar i = 0; i < RN; i++) begin : g_reg
    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        regs_r[i] <= REG_RST;
      end else if (take && wr_lo && wr_lo_addr == 5'(i)) begin
        regs_r[i] <= alu_res.lo;
      end else if (take && wr_hi && wr_hi_addr == 5'(i)) begin
        regs_r[i] <= alu_res.hi;
      end
    end
  end

  // ----------------------------------------
  // flow control and cycle count
  // ----------------------------------------
  always_comb begin
    cond = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    cyc = CYC_1;
    pc_nxt = pc_r + PC_W'(PC_NEXT);
    case (instr_i.op)
      add_imm_pair_op, sub_imm_pair_op, mult_unsigned_op, mult_signed_op,
      mult_signed_unsigned_op, frac_mult_unsigned_op, frac_mult_signed_op,
      frac_mult_mixed_op: begin
        cyc = CYC_2;
      end
      pointer_jump_op: begin
        cyc = CYC_2;
        pc_nxt = PC_W'(z_val);
      end
      pointer_call_op: begin
        cyc = CYC_3;
        pc_nxt = PC_W'(z_val);
      end
      cmp_skip_equal_op: begin
        is_skip = 1'b1;
        cond = (rd_val == rr_val);
      end
      skip_reg_bit_clear_op: begin
        is_skip = 1'b1;
        cond = ~rr_val[instr_i.bit_sel];
      end
      skip_io_bit_set_op: begin
        is_skip = 1'b1;
        cond = io_rdata_i[instr_i.bit_sel];
      end
      branch_status_set_op: begin
        is_branch = 1'b1;
        cond = status_flags_reg_r[instr_i.bit_sel];
      end
      branch_same_higher_op, branch_carry_clear_op: begin
        is_branch = 1'b1;
        cond = ~status_flags_reg_r[FL_C];
      end
      branch_signed_ge_op: begin
        is_branch = 1'b1;
        cond = ~(status_flags_reg_r[FL_N] ^ status_flags_reg_r[FL_V]);
      end
      default: ;
    endcase
    // skipping a two-word instruction costs one more cycle
    if (is_skip && cond) begin
      pc_nxt = pc_r + PC_W'(instr_i.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE);
      cyc = instr_i.next_two_word ? CYC_3 : CYC_2;
    end
    if (is_branch && cond) begin
      pc_nxt = PC_W'(pc_r + PC_W'(PC_NEXT) + koff);
      cyc = CYC_2;
    end
  end

  // branches and jumps keep the old status value
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_flags_reg_r <= STATUS_FLAGS_REG_RST;
    end else if (take) begin
      status_flags_reg_r <= alu_res.status_flags_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_r <= '0;
    end else if (take) begin
      pc_r <= pc_nxt;
    end
  end

  // results are written at the take edge; stalling only spends the cycles
  always_comb begin
    if (take) begin
      busy_nxt = cyc - CYC_1;
    end else if (busy_r != '0) begin
      busy_nxt = busy_r - CYC_1;
    end else begin
      busy_nxt = busy_r;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_r <= '0;
      ready_r <= 1'b1;
    end else if (ce_i) begin
      busy_r <= busy_nxt;
      ready_r <= (busy_nxt == '0);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ret_push_r <= 1'b0;
      ret_addr_r <= '0;
    end else if (ce_i) begin
      ret_push_r <= take && instr_i.op == pointer_call_op;
      if (take && instr_i.op == pointer_call_op) begin
        ret_addr_r <= pc_r + PC_W'(PC_NEXT);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dbg_r <= REG_RST;
    end else if (ce_i) begin
      dbg_r <= regs_r[dbg_sel_i];
    end
  end

  assign issue_ready_o = ready_r;
  assign pc_o = pc_r;
  assign ret_push_o = ret_push_r;
  assign ret_addr_o = ret_addr_r;
  assign status_flags_reg_o = status_flags_reg_r;
  assign dbg_data_o = dbg_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_add_sum: assert property (
    take && instr_i.op == add_regs_op |=>
      regs_r[$past(instr_i.rd)] == 8'($past(rd_val) + $past(rr_val)))
    else $error("add result wrong");

  a_pair_word: assert property (
    take && instr_i.op == add_imm_pair_op && instr_i.rd != REG_ZPTR_HI |=>
      {regs_r[$past(wr_hi_addr)], regs_r[$past(instr_i.rd)]} ==
      16'({$past(rd_hi_val), $past(rd_val)} + {8'h00, $past(instr_i.imm) & IMM_PAIR_MASK})
      && !issue_ready_o)
    else $error("pair add wrong or not stalled");

  a_sub_borrow: assert property (
    take && instr_i.op == sub_regs_op |=>
      status_flags_reg_o[FL_C] == ($past(rr_val) > $past(rd_val)))
    else $error("subtract borrow wrong");

  a_logic_flags: assert property (
    take && instr_i.op inside {and_regs_op, or_regs_op, xor_regs_op, clear_mask_op} |=>
      !status_flags_reg_o[FL_V] && status_flags_reg_o[FL_C] == $past(status_flags_reg_r[FL_C]))
    else $error("logic op flags wrong");

  a_test_keeps: assert property (
    take && instr_i.op == zero_minus_test_op |=>
      regs_r[$past(instr_i.rd)] == $past(rd_val) &&
      status_flags_reg_o[FL_Z] == ($past(rd_val) == '0))
    else $error("test changed register or zero flag wrong");

  a_mul_pair: assert property (
    take && instr_i.op == mult_unsigned_op |=>
      {regs_r[REG_PROD_HI], regs_r[REG_PROD_LO]} ==
      ({8'h00, $past(rd_val)} * {8'h00, $past(rr_val)}) && !issue_ready_o)
    else $error("unsigned product wrong or not stalled");

  a_jump_z: assert property (
    take && instr_i.op == pointer_jump_op |=> pc_o == PC_W'($past(z_val)) && !issue_ready_o)
    else $error("pointer jump target wrong");

  a_call_ret: assert property (
    take && instr_i.op == pointer_call_op && ce_i |=>
      ret_push_o && ret_addr_o == PC_W'($past(pc_r) + PC_W'(PC_NEXT)) && !issue_ready_o)
    else $error("call return point wrong");

  a_skip_equal: assert property (
    take && instr_i.op == cmp_skip_equal_op && rd_val == rr_val && !instr_i.next_two_word |=>
      pc_o == PC_W'($past(pc_r) + PC_W'(PC_SKIP_ONE)))
    else $error("equal skip distance wrong");

  a_cmp_nowrite: assert property (
    take && instr_i.op == cmp_imm_op |=> regs_r[$past(instr_i.rd)] == $past(rd_val))
    else $error("compare wrote a register");

  a_ge_branch: assert property (
    take && instr_i.op == branch_signed_ge_op && !(status_flags_reg_r[FL_N] ^ status_flags_reg_r[FL_V]) |=>
      pc_o == PC_W'($past(pc_r) + PC_W'(PC_NEXT) + $past(koff)))
    else $error("signed branch target wrong");

  a_branch_flags: assert property (
    take && instr_i.op inside {branch_carry_clear_op, branch_same_higher_op} |=>
      status_flags_reg_o == $past(status_flags_reg_r))
    else $error("branch changed flags");

  c_taken_branch: cover property (take && is_branch && cond);
  c_skip_two_word: cover property (take && is_skip && cond && instr_i.next_two_word);
  c_pointer_call: cover property (take && instr_i.op == pointer_call_op ##3 take);
endmodule

/* File: cab_fetch_model.sv */
/* cab_fetch_model: program memory side, hands decoded words to the core in order.
   assumes: push_i and word_i change just after rising edges of mclk_i. */
`timescale 1ns/1ps
module cab_fetch_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // bench side
  input wire logic push_i,
  input wire cab_pkg::cab_instr_t word_i,
  input wire logic slow_i,
  // core side
  input wire logic ready_i,
  output logic valid_o,
  output cab_pkg::cab_instr_t instr_o
);
  import cab_pkg::*;
  cab_instr_t q[$];
  // a word stays up until taken; slow mode idles one cycle after each take
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q.delete();
      valid_o <= 1'b0;
      instr_o <= '0;
    end else begin
      if (valid_o && ready_i) void'(q.pop_front());
      if (push_i) q.push_back(word_i);
      valid_o <= q.size() != 0 && !(slow_i && valid_o && ready_i);
      instr_o <= q.size() != 0 ? q[0] : ~instr_o;
    end
  end
endmodule

/* File: cab_core_tb.sv */
/* cab_core_tb: self-checking bench; a model predicts registers, flags, pc and stall.
   assumes: cab_pkg and cab_fetch_model are compiled before it. */
`timescale 1ns/1ps
module cab_core_tb;
  import cab_pkg::*;
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] fl;
    logic [4:0] r;
    logic [7:0] v;
    logic one;
    logic call;
    logic [15:0] ra;
  } cab_note_t;
  logic mclk_i = 1'b0, resetn_i = 1'b0, push = 1'b0, slow = 1'b0, tk = 1'b0, pend = 1'b0, rdy, vld;
  logic ce = 1'b0, ced = 1'b0, rp;
  logic [7:0] io = 8'h00, fo, dd, fl;
  logic [4:0] dsel = 5'h00;
  logic [15:0] pco, pc, ra;
  logic [7:0] rf [32];
  cab_instr_t w = '0, ins;
  cab_note_t nq[$], cn;
  int error_cnt = 0, n_checks = 0, seed = 32'h3b7977da;
  always #25 mclk_i = ~mclk_i;
  cab_core i_cab_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .instr_valid_i(vld), .instr_i(ins),
    .issue_ready_o(rdy), .io_rdata_i(io), .pc_o(pco), .ret_push_o(rp), .ret_addr_o(ra),
    .status_flags_reg_o(fo), .dbg_sel_i(dsel), .dbg_data_o(dd));
  cab_fetch_model i_cab_fetch_model (.mclk_i(mclk_i), .resetn_i(resetn_i), .push_i(push), .word_i(w),
    .slow_i(slow), .ready_i(rdy & ce), .valid_o(vld), .instr_o(ins));
  task automatic chk(string nm, logic [15:0] e, s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic void lf(logic [7:0] y, logic v);
    fl[1] = y == 8'h00;
    fl[2] = y[7];
    fl[3] = v;
    fl[4] = y[7] ^ v;
  endfunction
  function automatic logic [7:0] lg(logic [7:0] y);
    lf(y, 1'b0);
    return y;
  endfunction
  function automatic logic [7:0] af(logic [7:0] a, b, logic s, c);
    logic [8:0] t;
    logic [4:0] h;
    t = s ? {1'b0, a} - b - c : {1'b0, a} + b + c;
    h = s ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
    lf(t[7:0], (a[7] ^ t[7]) & (a[7] ^ b[7] ^ !s));
    fl[0] = t[8];
    fl[5] = h[4];
    return t[7:0];
  endfunction
  // model the word, note the outcome, then hand the word to program memory
  task automatic iss(cab_op_t op, logic [4:0] d, s, logic [7:0] k, logic [2:0] b, logic tw);
    logic [7:0] a, r, y;
    logic [15:0] p, m, fr;
    logic [16:0] t;
    logic z0, sk, br;
    int cy;
    cab_note_t n;
    a = rf[d];
    r = rf[s];
    y = a;
    p = pc + 16'd1;
    sk = 1'b0;
    br = 1'b0;
    cy = 1;
    n.r = d;
    case (op)
      add_regs_op, add_carry_op: y = af(a, r, 1'b0, op == add_carry_op && fl[0]);
      sub_regs_op, sub_const_op, sub_carry_op, sub_const_carry_op, cmp_regs_op, cmp_carry_op, cmp_imm_op: begin
        z0 = fl[1];
        y = af(a, op inside {sub_const_op, sub_const_carry_op, cmp_imm_op} ? k : r, 1'b1,
          op inside {sub_carry_op, sub_const_carry_op, cmp_carry_op} && fl[0]);
        if (op inside {sub_carry_op, sub_const_carry_op, cmp_carry_op}) fl[1] = fl[1] && z0;
        if (op inside {cmp_regs_op, cmp_carry_op, cmp_imm_op}) y = a;
      end
      and_regs_op: y = lg(a & r);
      and_const_op: y = lg(a & k);
      or_regs_op: y = lg(a | r);
      or_const_op: y = lg(a | k);
      xor_regs_op: y = lg(a ^ r);
      clear_mask_op: y = lg(a & (ALL_ONES - k));
      zero_minus_test_op: y = lg(a & a);
      add_imm_pair_op, sub_imm_pair_op: begin
        m = {rf[d + 5'd1], a};
        t = op == add_imm_pair_op ? {1'b0, m} + k[5:0] : {1'b0, m} - k[5:0];
        fl[0] = t[16];
        fl[1] = t[15:0] == 16'h0000;
        fl[2] = t[15];
        fl[3] = op == add_imm_pair_op ? !m[15] && t[15] : m[15] && !t[15];
        fl[4] = fl[2] ^ fl[3];
        rf[d + 5'd1] = t[15:8];
        y = t[7:0];
        cy = 2;
      end
      mult_unsigned_op, mult_signed_op, mult_signed_unsigned_op, frac_mult_unsigned_op, frac_mult_signed_op,
      frac_mult_mixed_op: begin
        m = a * r;
        if (op inside {mult_signed_op, frac_mult_signed_op}) m = $signed(a) * $signed(r);
        if (op inside {mult_signed_unsigned_op, frac_mult_mixed_op}) m = $signed(a) * $signed({1'b0, r});
        fr = op >= frac_mult_unsigned_op ? m << 1 : m;
        fl[0] = m[15];
        fl[1] = fr == 16'h0000;
        {rf[1], rf[0]} = fr;
        n.r = 5'h01;
        cy = 2;
      end
      pointer_jump_op, pointer_call_op: begin
        p = {rf[31], rf[30]};
        cy = op == pointer_jump_op ? 2 : 3;
      end
      cmp_skip_equal_op: sk = a == r;
      skip_reg_bit_clear_op: sk = !r[b];
      skip_io_bit_set_op: sk = io[b];
      branch_status_set_op: br = fl[b];
      branch_same_higher_op, branch_carry_clear_op: br = !fl[0];
      branch_signed_ge_op: br = !(fl[2] ^ fl[3]);
      default: ;
    endcase
    if (sk) p = pc + 16'd2 + tw;
    if (sk) cy = 2 + tw;
    if (br) p = pc + 16'd1 + {{9{k[6]}}, k[6:0]};
    if (br) cy = 2;
    rf[d] = y;
    n.pc = p;
    n.fl = fl;
    n.v = rf[n.r];
    n.one = cy == 1;
    n.call = op == pointer_call_op;
    n.ra = pc + 16'd1;
    pc = p;
    @(posedge mclk_i);
    push <= 1'b1;
    w <= '{op, d, s, k, b, tw};
    nq.push_back(n);
  endtask
  // enable drops about one edge in four, so frozen cycles fall inside stalls and streams
  always @(posedge mclk_i) ce <= resetn_i && ($random(seed) % 4 != 0);
  always @(posedge mclk_i) begin
    tk <= vld && rdy && ce;
    ced <= ce;
    if (vld && rdy && ce) dsel <= nq[0].r;
  end
  // the register view follows one enabled edge behind the take
  always @(negedge mclk_i) begin
    if (pend && ced) begin
      chk("register", {8'h00, cn.v}, {8'h00, dd});
      pend = 1'b0;
    end
    if (tk) begin
      pend = 1'b1;
      cn = nq.pop_front();
      chk("pc", cn.pc, pco);
      chk("flags", {8'h00, cn.fl}, {8'h00, fo});
      chk("ready", {15'h0000, cn.one}, {15'h0000, rdy});
      chk("return push", {15'h0000, cn.call}, {15'h0000, rp});
      if (cn.call) chk("return address", cn.ra, ra);
    end
  end
  initial begin
    logic [7:0] a, b;
    cab_op_t o;
    foreach (rf[i]) rf[i] = 8'h00;
    pc = 16'h0000;
    fl = 8'h00;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    chk("reset pc", 16'h0000, pco);
    repeat (6) begin
      @(posedge mclk_i);
      a = 8'($random(seed));
      b = 8'($random(seed));
      io <= 8'($random(seed));
      slow <= a[0];
      o = o.first();
      iss(and_const_op, 2, 0, 8'h00, 0, 0);
      iss(sub_const_op, 2, 0, 8'h00 - a, 0, 0);
      iss(and_const_op, 3, 0, 8'h00, 0, 0);
      iss(sub_const_op, 3, 0, 8'h00 - b, 0, 0);
      iss(and_const_op, 30, 0, 8'h00, 0, 0);
      iss(sub_const_op, 30, 0, a ^ b, 0, 0);
      repeat (o.num()) begin
        iss(o, 2, 3, b, a[2:0], a[7]);
        iss(nop_op, 0, 0, 8'h00, 0, 0);
        o = o.next();
      end
      // equal operands always skip, one or two words
      iss(cmp_skip_equal_op, 3, 3, b, 0, a[1]);
      @(posedge mclk_i);
      push <= 1'b0;
      repeat (400) begin
        @(posedge mclk_i);
        if (nq.size() == 0 && rdy) break;
      end
      if (nq.size() != 0 || !rdy) error_cnt++;
    end
    repeat (8) @(posedge mclk_i);
    results();
  end
  // far beyond the expected run of some one thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    results();
  end
endmodule
